// ### inc/smsp_cfg.svh
// Register map, field positions and counts of the serial port block
`ifndef SMSP_CFG_SVH
`define SMSP_CFG_SVH
`define SMSP_A_CTRL   32'h0000_0000
`define SMSP_A_STAT   32'h0000_0004
`define SMSP_A_DATA   32'h0000_0008
`define SMSP_A_DDR    32'h0000_000C
`define SMSP_A_GPO    32'h0000_0010
`define SMSP_CB_IRQ   3'h7
`define SMSP_CB_EN    3'h6
`define SMSP_CB_OD    3'h5
`define SMSP_CB_MST   3'h4
`define SMSP_CB_CPOL  3'h3
`define SMSP_CB_CPHA  3'h2
`define SMSP_SB_TC    3'h7
`define SMSP_SB_WRITE_COLLISION_FLAG  3'h6
`define SMSP_SB_MODE_FAULT_FLAG  3'h4
`define SMSP_P_MISO   2'h0
`define SMSP_P_MOSI   2'h1
`define SMSP_P_SCK    2'h2
`define SMSP_P_SS     2'h3
`define SMSP_DDR_SS   3'h5
`define SMSP_CTRL_RST 8'h00
`define SMSP_DDR_RST  6'h00
`define SMSP_HALF_R0  5'h01
`define SMSP_HALF_R1  5'h02
`define SMSP_HALF_R2  5'h08
`define SMSP_HALF_R3  5'h10
`define SMSP_LAST_EDG 4'hF
`define SMSP_LAST_BIT 3'h7
`define SMSP_RESP_OK  2'h0
`define SMSP_RESP_ERR 2'h2
`endif

// ### inc/smsp_pkg.sv
// Types of the serial port block
`default_nettype none
package smsp_pkg;
  typedef enum logic {
    SMSP_IDLE = 1'b0,
    SMSP_RUN  = 1'b1
  } smsp_mst_state_type;
  typedef logic [7:0] smsp_byte_type;
endpackage
`default_nettype wire

// ### tb/smsp_slave_model.sv
// Behavioural far-end serial slave used while the block is master
`default_nettype none
module smsp_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shift_q;
  always @(posedge load) begin
    shift_q = tx_byte;
    if (!cpha) begin
      miso    = shift_q[7];
      shift_q = {shift_q[6:0], ~shift_q[0]};
    end
  end
  // sample and shift on opposite edges
  always @(sck) begin
    if (sck ^ cpol ^ cpha) begin
      rx_byte = {rx_byte[6:0], mosi};
    end else begin
      miso    = shift_q[7];
      shift_q = {shift_q[6:0], ~shift_q[0]};
    end
  end
endmodule // smsp_slave_model
`default_nettype wire

// ### tb/spi_master_slave_port_bench.sv
// Self-checking bench of the serial port block
`include "smsp_cfg.svh"
`default_nettype none
module spi_master_slave_port_bench import smsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic          ref_clk, reset, cpu_irq_mask, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid, irq_req;
  logic          ss_ext, cpol, cpha, load, miso_m, sck_q, sck_ext, mosi_ext;
  logic [31:0]   awaddr, wdata, araddr, rdata;
  logic [1:0]    bresp, rresp;
  logic [3:0]    pin_out, pin_oe_n, pin_lvl;
  smsp_byte_type tx_m, rx_m;
  int            failures, check_count, toggles, run_len, gap_seen;
  int            divs [4] = '{2, 4, 16, 32};

  // Released pins take the bench select, clock and MOSI levels and the slave model MISO
  assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & {ss_ext, sck_ext, mosi_ext, miso_m});

  smsp_core dut_u (.ref_clk, .reset, .clk_en(1'b1), .cpu_irq_mask, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in(pin_lvl), .pin_out,
    .pin_oe_n, .irq_req);
  smsp_slave_model slv_u (.sck(pin_lvl[2]), .mosi(pin_lvl[1]), .cpol, .cpha, .load,
    .tx_byte(tx_m), .miso(miso_m), .rx_byte(rx_m));

  always #2 ref_clk = ~ref_clk;

  // Serial clock toggle count and spacing
  always @(posedge ref_clk) begin
    sck_q <= pin_lvl[2];
    if (pin_lvl[2] !== sck_q) begin
      toggles  <= toggles + 1;
      gap_seen <= run_len;
      run_len  <= 1;
    end else run_len <= run_len + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    repeat (64) begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    repeat (64) begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata; r = rresp;
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_tc(output logic [31:0] v);
    logic [1:0] r;
    repeat (200) begin
      rd(`SMSP_A_STAT, v, r);
      if (v[7] === 1'b1) break;
    end
  endtask

  task automatic t_reset();
    logic [31:0] v; logic [1:0] r;
    check(pin_oe_n, 4'hF);
    check(irq_req, 1'b0);
    rd(`SMSP_A_CTRL, v, r); check(v, 32'h0);
    rd(`SMSP_A_STAT, v, r); check(v, 32'h0);
    rd(`SMSP_A_DDR, v, r); check(v, 32'h0);
    rd(32'h40, v, r); check(v, 32'h0);
    check(r, 2'h2);
    wr(32'h40, 8'h5A, r); check(r, 2'h2);
  endtask

  task automatic t_master(input int i, input smsp_byte_type d, input smsp_byte_type s);
    logic [31:0] v; logic [1:0] r; int t0;
    cpol <= i[0]; cpha <= i[1];
    wr(`SMSP_A_DDR, 8'h3C, r);
    wr(`SMSP_A_CTRL, {4'h5, i[0], i[1], i[1:0]}, r);
    tx_m <= s; load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t0 = toggles;
    wr(`SMSP_A_DATA, d, r);
    wait_tc(v);
    check(v, 32'h80);
    check(toggles - t0, 16);
    check(gap_seen * 2, divs[i]);
    check(pin_lvl[2], i[0]);
    check(pin_oe_n[0], 1'b1);
    check(rx_m, d);
    rd(`SMSP_A_DATA, v, r); check(v, s);
    rd(`SMSP_A_STAT, v, r); check(v, 32'h0);
  endtask

  task automatic t_collide();
    logic [31:0] v; logic [1:0] r; int t0;
    cpol <= 1'b0; cpha <= 1'b0;
    wr(`SMSP_A_CTRL, 8'h53, r);
    tx_m <= 8'h96; load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
    wr(`SMSP_A_DATA, 8'h5A, r);
    wr(`SMSP_A_DATA, 8'hFF, r);
    repeat (300) @(posedge ref_clk);
    t0 = toggles;
    wr(`SMSP_A_DATA, 8'h11, r);
    repeat (40) @(posedge ref_clk);
    check(toggles - t0, 0);
    check(rx_m, 8'h5A);
    rd(`SMSP_A_STAT, v, r); check(v, 32'hC0);
    rd(`SMSP_A_DATA, v, r); check(v, 32'h96);
    rd(`SMSP_A_STAT, v, r); check(v, 32'h0);
  endtask

  task automatic t_fault();
    logic [31:0] v; logic [1:0] r;
    wr(`SMSP_A_DDR, 8'h1C, r);
    wr(`SMSP_A_CTRL, 8'hD0, r);
    ss_ext <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check(irq_req, 1'b0);
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(irq_req, 1'b1);
    rd(`SMSP_A_STAT, v, r); check(v, 32'h10);
    rd(`SMSP_A_CTRL, v, r); check(v, 32'hC0);
    rd(`SMSP_A_DDR, v, r); check(v, 32'h0);
    ss_ext <= 1'b1;
    wr(`SMSP_A_CTRL, 8'h40, r);
    rd(`SMSP_A_STAT, v, r); check(v, 32'h0);
    check(irq_req, 1'b0);
  endtask

  task automatic t_slave();
    logic [1:0] r;
    wr(`SMSP_A_DDR, 8'h3C, r);
    repeat (4) @(posedge ref_clk);
    check(pin_oe_n, 4'hF);
    ss_ext <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check(pin_oe_n, 4'hE);
    wr(`SMSP_A_DDR, 8'h00, r);
    repeat (2) @(posedge ref_clk);
    check(pin_oe_n[0], 1'b1);
    ss_ext <= 1'b1;
  endtask

  task automatic t_slave_xfer();
    logic [31:0] v; logic [1:0] r; smsp_byte_type got; smsp_byte_type pat;
    pat = 8'h6B;
    sck_ext <= 1'b0;
    wr(`SMSP_A_DDR, 8'h04, r);
    wr(`SMSP_A_DATA, 8'hC3, r);
    // select low for the whole byte
    ss_ext <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int b = 7; b >= 0; b--) begin
      mosi_ext <= pat[b];
      repeat (6) @(posedge ref_clk);
      sck_ext <= 1'b1;
      got[b] = pin_lvl[0];
      repeat (6) @(posedge ref_clk);
      sck_ext <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    ss_ext <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check(got, 8'hC3);
    check(pin_oe_n[0], 1'b1);
    rd(`SMSP_A_STAT, v, r); check(v, 32'h80);
    rd(`SMSP_A_DATA, v, r); check(v, 32'h6B);
    sck_ext <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0; reset = 1'b1; cpu_irq_mask = 1'b1; ss_ext = 1'b1;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = '0; wdata = '0; araddr = '0; cpol = 1'b0; cpha = 1'b0; load = 1'b0;
    tx_m = '0; sck_q = 1'b0; failures = 0; check_count = 0;
    sck_ext = 1'b1; mosi_ext = 1'b1;
    toggles = 0; run_len = 0; gap_seen = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    for (int i = 0; i < 4; i++) t_master(i, smsp_byte_type'(8'hA5 ^ i), smsp_byte_type'(8'h3C + i));
    t_collide();
    t_fault();
    t_slave();
    t_slave_xfer();
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    tally_and_finish();
  end
endmodule // spi_master_slave_port_bench
`default_nettype wire

// ### verilog/smsp_core.sv
// Serial peripheral port, master or slave, with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "smsp_cfg.svh"
`default_nettype none
module smsp_core
  import smsp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        cpu_irq_mask,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  pin_in,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe_n,
  output logic             irq_req
);

  function automatic logic f_mapped(input logic [31:0] a);
    f_mapped = (a == `SMSP_A_CTRL) || (a == `SMSP_A_STAT) || (a == `SMSP_A_DATA)
            || (a == `SMSP_A_DDR) || (a == `SMSP_A_GPO);
  endfunction

  function automatic logic [4:0] f_half(input logic [1:0] r);
    unique case (r)
      2'b00: f_half = `SMSP_HALF_R0;
      2'b01: f_half = `SMSP_HALF_R1;
      2'b10: f_half = `SMSP_HALF_R2;
      2'b11: f_half = `SMSP_HALF_R3;
    endcase
  endfunction

  logic [7:0]         ctrl_ff;
  logic [5:0]         ddr_ff;
  logic [5:0]         gpo_ff;
  logic               tc_ff, write_collision_flag_ff, mode_fault_flag_ff;
  logic               tc_seen_ff, write_collision_flag_seen_ff, mode_fault_flag_seen_ff;
  smsp_byte_type      sh_ff, rx_buf_ff;
  logic               out_bit_ff;
  logic [3:0]         sync1_ff, sync2_ff;
  logic               sck_prev_ff;
  smsp_mst_state_type st_ff;
  logic [4:0]         div_ff;
  logic [3:0]         edge_ff;
  logic               sck_act_ff;
  logic [2:0]         s_cnt_ff;
  logic               s_act_ff;
  logic               aw_hold_ff, w_hold_ff, wstb_ff;
  logic [31:0]        aw_addr_ff;
  logic [7:0]         w_data_ff;
  logic               irq_ff;
  logic [2:0]         m_smp_ff, m_dn_ff;
  smsp_byte_type      rx_m_ff;

  logic en, mst, cpol, cpha, ss_lo, s_sel, act, busy;
  logic wr_go, rd_go, wr_ctrl, wr_data, rd_stat, rd_data, data_acc;
  logic wr_data_ok, load, coll, mode_fault_flag_ev;
  logic m_tick, m_done, lead, trail, sample, shift, sin, done, s_done;
  logic [3:0] own, role, spi_val, drive, val;

  assign en    = ctrl_ff[`SMSP_CB_EN];
  assign mst   = ctrl_ff[`SMSP_CB_MST];
  assign cpol  = ctrl_ff[`SMSP_CB_CPOL];
  assign cpha  = ctrl_ff[`SMSP_CB_CPHA];
  assign ss_lo = !sync2_ff[`SMSP_P_SS];

  // Bus handshakes
  assign awready = !aw_hold_ff && !bvalid;
  assign wready  = !w_hold_ff && !bvalid;
  assign arready = !rvalid;
  assign wr_go   = aw_hold_ff && w_hold_ff && !bvalid;
  assign rd_go   = arvalid && arready;
  assign wr_ctrl = wr_go && wstb_ff && (aw_addr_ff == `SMSP_A_CTRL);
  assign wr_data = wr_go && (aw_addr_ff == `SMSP_A_DATA);
  assign rd_stat = rd_go && (araddr == `SMSP_A_STAT);
  assign rd_data = rd_go && (araddr == `SMSP_A_DATA);
  assign data_acc = wr_data || rd_data;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= 32'h0000_0000;
      w_data_ff  <= 8'h00;
      wstb_ff    <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `SMSP_RESP_OK;
    end else if (clk_en) begin
      if (awvalid && awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= wdata[7:0];
        wstb_ff   <= wstrb[0];
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= f_mapped(aw_addr_ff) ? `SMSP_RESP_OK : `SMSP_RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `SMSP_RESP_OK;
    end else if (clk_en) begin
      if (rd_go) begin
        rvalid <= 1'b1;
        rresp  <= f_mapped(araddr) ? `SMSP_RESP_OK : `SMSP_RESP_ERR;
        unique case (araddr)
          `SMSP_A_CTRL: rdata <= {24'h00_0000, ctrl_ff};
          `SMSP_A_STAT: rdata <= {24'h00_0000, tc_ff, write_collision_flag_ff, 1'b0, mode_fault_flag_ff, 4'h0};
          `SMSP_A_DATA: rdata <= {24'h00_0000, rx_buf_ff};
          `SMSP_A_DDR:  rdata <= {26'h000_0000, ddr_ff};
          `SMSP_A_GPO:  rdata <= {26'h000_0000, gpo_ff};
          default:      rdata <= 32'h0000_0000;
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_ff    <= 4'hF;
      sync2_ff    <= 4'hF;
      sck_prev_ff <= 1'b0;
    end else if (clk_en) begin
      sync1_ff    <= pin_in;
      sync2_ff    <= sync1_ff;
      sck_prev_ff <= act;
    end
  end

  assign mode_fault_flag_ev = en && mst && !ddr_ff[`SMSP_DDR_SS] && ss_lo;

  assign wr_data_ok = wr_data && wstb_ff && !(tc_ff && !tc_seen_ff);
  assign coll = wr_data_ok && busy;
  assign load = wr_data_ok && !busy;

  // fault clears master and pin directions
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff <= `SMSP_CTRL_RST;
      ddr_ff  <= `SMSP_DDR_RST;
      gpo_ff  <= `SMSP_DDR_RST;
    end else if (clk_en) begin
      if (wr_ctrl)
        ctrl_ff <= w_data_ff;
      if (wr_go && wstb_ff && (aw_addr_ff == `SMSP_A_DDR))
        ddr_ff <= w_data_ff[5:0];
      if (wr_go && wstb_ff && (aw_addr_ff == `SMSP_A_GPO))
        gpo_ff <= w_data_ff[5:0];
      if (mode_fault_flag_ev) begin
        ctrl_ff[`SMSP_CB_MST] <= 1'b0;
        ddr_ff[5:2]           <= 4'h0;
      end
    end
  end

  // Status flags, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tc_ff        <= 1'b0;
      write_collision_flag_ff      <= 1'b0;
      mode_fault_flag_ff      <= 1'b0;
      tc_seen_ff   <= 1'b0;
      write_collision_flag_seen_ff <= 1'b0;
      mode_fault_flag_seen_ff <= 1'b0;
    end else if (clk_en) begin
      if (rd_stat && tc_ff)
        tc_seen_ff <= 1'b1;
      else if (data_acc)
        tc_seen_ff <= 1'b0;
      if (rd_stat && write_collision_flag_ff)
        write_collision_flag_seen_ff <= 1'b1;
      else if (data_acc)
        write_collision_flag_seen_ff <= 1'b0;
      if (rd_stat && mode_fault_flag_ff)
        mode_fault_flag_seen_ff <= 1'b1;
      else if (wr_ctrl)
        mode_fault_flag_seen_ff <= 1'b0;
      if (done)
        tc_ff <= 1'b1;
      else if (data_acc && tc_seen_ff)
        tc_ff <= 1'b0;
      if (coll)
        write_collision_flag_ff <= 1'b1;
      else if (data_acc && write_collision_flag_seen_ff)
        write_collision_flag_ff <= 1'b0;
      if (mode_fault_flag_ev)
        mode_fault_flag_ff <= 1'b1;
      else if (wr_ctrl && mode_fault_flag_seen_ff)
        mode_fault_flag_ff <= 1'b0;
    end
  end

  assign m_tick = (st_ff == SMSP_RUN) && (div_ff == f_half(ctrl_ff[1:0]) - 5'h01);
  assign m_done = m_tick && (edge_ff == `SMSP_LAST_EDG);

  // master transfer from data write to flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff      <= SMSP_IDLE;
      div_ff     <= 5'h00;
      edge_ff    <= 4'h0;
      sck_act_ff <= 1'b0;
    end else if (clk_en) begin
      unique case (st_ff)
        SMSP_IDLE: begin
          div_ff     <= 5'h00;
          edge_ff    <= 4'h0;
          sck_act_ff <= 1'b0;
          if (load && mst && !mode_fault_flag_ev)
            st_ff <= SMSP_RUN;
        end
        SMSP_RUN: begin
          div_ff <= m_tick ? 5'h00 : div_ff + 5'h01;
          if (m_tick) begin
            sck_act_ff <= !sck_act_ff;
            edge_ff    <= edge_ff + 4'h1;
          end
          if (m_done || mode_fault_flag_ev || !mst || !en)
            st_ff <= SMSP_IDLE;
        end
      endcase
    end
  end

  // slave shift clock gated by select in either phase
  assign act   = sync2_ff[`SMSP_P_SCK] ^ cpol;
  assign s_sel = en && !mst && ss_lo;
  assign lead  = mst ? (m_tick && !sck_act_ff) : (s_sel && act && !sck_prev_ff);
  assign trail = mst ? (m_tick && sck_act_ff) : (s_sel && !act && sck_prev_ff);
  // data changes half cycle before sampling
  assign sample = cpha ? trail : lead;
  assign shift  = cpha ? lead : trail;
  assign sin    = mst ? sync2_ff[`SMSP_P_MISO] : sync2_ff[`SMSP_P_MOSI];
  assign s_done = !mst && sample && (s_cnt_ff == `SMSP_LAST_BIT);
  assign done   = m_dn_ff[2] || s_done;

  // phase 1 slave active from first edge
  // select may stay low between bytes
  assign busy = (st_ff == SMSP_RUN) || (|m_dn_ff) || (en && !mst && (cpha ? s_act_ff : ss_lo));

  // master MISO sampled after pin register and synchroniser lag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      m_smp_ff <= 3'h0;
      m_dn_ff  <= 3'h0;
      rx_m_ff  <= 8'h00;
    end else if (clk_en) begin
      if (mode_fault_flag_ev) begin
        m_smp_ff <= 3'h0;
        m_dn_ff  <= 3'h0;
      end else begin
        m_smp_ff <= {m_smp_ff[1:0], mst && sample};
        m_dn_ff  <= {m_dn_ff[1:0], m_done};
      end
      if (m_smp_ff[2])
        rx_m_ff <= {rx_m_ff[6:0], sync2_ff[`SMSP_P_MISO]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_cnt_ff <= 3'h0;
      s_act_ff <= 1'b0;
    end else if (clk_en) begin
      if (!s_sel)
        s_cnt_ff <= 3'h0;
      else if (sample)
        s_cnt_ff <= s_cnt_ff + 3'h1;
      if (!s_sel || s_done)
        s_act_ff <= 1'b0;
      else if (lead)
        s_act_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sh_ff      <= 8'h00;
      out_bit_ff <= 1'b0;
      rx_buf_ff  <= 8'h00;
    end else if (clk_en) begin
      if (load) begin
        sh_ff      <= w_data_ff;
        out_bit_ff <= w_data_ff[7];
      end else begin
        if (sample)
          sh_ff <= {sh_ff[6:0], sin};
        if (shift)
          out_bit_ff <= sh_ff[7];
      end
      if (m_dn_ff[2])
        rx_buf_ff <= m_smp_ff[2] ? {rx_m_ff[6:0], sync2_ff[`SMSP_P_MISO]} : rx_m_ff;
      else if (s_done)
        rx_buf_ff <= {sh_ff[6:0], sin};
    end
  end

  // select pin released to GP in master when its DDR bit is set
  assign own = {en && !(mst && ddr_ff[`SMSP_DDR_SS]), en, en, en};
  assign role    = {1'b0, mst, mst, !mst && ss_lo};
  assign spi_val = {1'b1, cpol ^ sck_act_ff, out_bit_ff, out_bit_ff};

  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign drive[i] = ddr_ff[i+2] && (own[i] ? role[i] : 1'b1);
    assign val[i]   = own[i] ? spi_val[i] : gpo_ff[i+2];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_out  <= 4'hF;
      pin_oe_n <= 4'hF;
    end else if (clk_en) begin
      pin_out  <= val;
      pin_oe_n <= ~(drive & (~val | {4{!ctrl_ff[`SMSP_CB_OD]}}));
    end
  end

  // interrupt gated by enable and mask
  always_ff @(posedge ref_clk) begin
    if (reset)
      irq_ff <= 1'b0;
    else if (clk_en)
      irq_ff <= ctrl_ff[`SMSP_CB_IRQ] && !cpu_irq_mask && (tc_ff || mode_fault_flag_ff);
  end
  assign irq_req = irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset || !clk_en);

  property p_miso_off;
    en && !mst && !ss_lo && ddr_ff[2] |=> pin_oe_n[0];
  endproperty
  a_miso_off: assert property (p_miso_off) else $error("slave MISO driven");

  property p_div4;
    load && mst && ctrl_ff[1:0] == 2'b01 |=> !m_tick ##1 m_tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 wrong");

  property p_div2;
    load && mst && ctrl_ff[1:0] == 2'b00 |=> m_tick;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by 2 wrong");

  property p_coll;
    coll |=> write_collision_flag_ff && $stable(tc_ff);
  endproperty
  a_coll: assert property (p_coll) else $error("collision not flagged");

  property p_fault;
    mode_fault_flag_ev |=> mode_fault_flag_ff && !mst && ddr_ff[5:2] == 4'h0 && st_ff == SMSP_IDLE;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not handled");

  property p_idle_sck;
    en && mst && st_ff == SMSP_IDLE |=> pin_out[2] == $past(cpol);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("SCK idle level wrong");

  property p_irq;
    ctrl_ff[`SMSP_CB_IRQ] && !cpu_irq_mask && tc_ff |=> irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_inhibit;
    wr_data && tc_ff && !tc_seen_ff && st_ff == SMSP_IDLE |=> st_ff == SMSP_IDLE;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("write not inhibited");

  property p_sdone;
    s_done |=> tc_ff && rx_buf_ff[0] == $past(sin);
  endproperty
  a_sdone: assert property (p_sdone) else $error("slave completion wrong");

endmodule // smsp_core
`default_nettype wire
